// *** amc_scan_controller.sv ***
// What this block does
// - Clearing enable resets scan logic, averages and FIFO pointers.
// - Setting enable lets conversions run on their own.
// - Scan starts only if enabled, a slot enabled, and triggered.
// - Each slot averages its configured sample count into one result.
// - Single mode: one trigger, one scan; FIFO written on completed averages.
// - Each pin edge of chosen polarity starts one full scan.
// - With repeat enabled, timer pulses act as scan triggers.
// - Timer pulses ignored until a first normal trigger.
// - Once repeating, each timer pulse alone launches a scan.
// - Software source: a trigger register write starts scanning.
// - Mode zero keeps reference and converter powered between scans.
// - Mode one powers down between scans, keeps calibration.
// - Mode one runs scans back to back while triggers pend.
// - Scan end with nothing pending drops to low power, except in mode zero.
// - Mode two starts each power-up cold with settle and recalibration.
// - Fast oscillator requested from clock generator by handshake.
// - Six interrupt status bits, each with its own enable.
// - Sixth source flags a result inside the limits.
// - Conversion complete sets when a result is pushed.
// - Scan complete sets once all enabled slots are sampled.
//
// The implementer's own choices: the placing of the registers and the address-and-strobe port.
module amc_scan_controller #(
  parameter int COLD_CYCLES = amc_pkg::COLD_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdata,
  // Trigger sources and power grant
  input wire logic [3:0] extTrigger,
  input wire logic timerTrigger,
  input wire logic subsystemPowerEnable,
  // Clock generator handshake
  output logic fastClkReq,
  input wire logic fastClkAck,
  // Analog converter
  output logic analogPowerOn,
  output logic refBufferOn,
  output logic convClockOn,
  output logic calibrateReq,
  output logic sampleReq,
  output logic [2:0] sampleSlot,
  output logic [3:0] sampleChannel,
  input wire logic sampleDone,
  input wire logic [13:0] sampleData,
  // Interrupt summary
  output logic intActive
);

  localparam int NS = amc_pkg::NUM_SLOTS;
  localparam int FCW = $clog2(amc_pkg::FIFO_DEPTH + 1);

  // ********************************
  // Reset release
  // ********************************
  logic [1:0] rstSync;
  logic rstIn_n;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstSync <= 2'h0;
    end else begin
      rstSync <= {rstSync[0], 1'b1};
    end
  end
  assign rstIn_n = rstSync[1];

  // ********************************
  // Helpers
  // ********************************
  // Lowest enabled slot at or above start; bit 3 marks that one was found
  function automatic logic [3:0] firstFrom(input logic [7:0] mask, input logic [3:0] start);
    logic [3:0] r;
    r = 4'h0;
    for (int i = NS - 1; i >= 0; i--) begin
      if (mask[i] && (4'(i) >= start)) begin
        r = {1'b1, 3'(i)};
      end
    end
    return r;
  endfunction : firstFrom

  // ********************************
  // Register group
  // ********************************
  logic cfgEnable, next_cfgEnable;
  logic cfgRepeat, next_cfgRepeat;
  logic [1:0] cfgPowerMode, next_cfgPowerMode;
  logic [2:0] cfgTrigSel, next_cfgTrigSel;
  logic cfgTrigPol, next_cfgTrigPol;
  logic [7:0] slotCfg [NS];
  logic [7:0] next_slotCfg [NS];
  logic [13:0] upperLimit, next_upperLimit, lowerLimit, next_lowerLimit;
  logic [5:0] intEnable, next_intEnable, intStatus, next_intStatus;
  logic [31:0] next_regRdata;
  logic next_intActive;
  logic swTrigWrite, fifoPop;
  logic [5:0] intEvents;
  logic [amc_pkg::FIFO_W-1:0] fifoHead;
  logic [FCW-1:0] fifoCount;
  logic funcEnable;
  logic [2:0] stateCode;
  logic repeatArmed, pending, calibrated;

  // Subsystem power overrides the functional enable
  assign funcEnable = cfgEnable && subsystemPowerEnable;

  always_comb begin
    next_cfgEnable = cfgEnable;
    next_cfgRepeat = cfgRepeat;
    next_cfgPowerMode = cfgPowerMode;
    next_cfgTrigSel = cfgTrigSel;
    next_cfgTrigPol = cfgTrigPol;
    next_slotCfg = slotCfg;
    next_upperLimit = upperLimit;
    next_lowerLimit = lowerLimit;
    next_intEnable = intEnable;
    next_regRdata = 32'h0;
    swTrigWrite = regWrite && (regAddr == amc_pkg::OFS_SWT);
    fifoPop = regWrite && (regAddr == amc_pkg::OFS_FIFO);
    next_intStatus = intStatus;
    if (regWrite && (regAddr == amc_pkg::OFS_INTCLR)) begin
      next_intStatus = intStatus & ~regWdata[5:0];
    end
    // New events win over a clear in the same cycle
    next_intStatus = next_intStatus | intEvents;
    if (regWrite) begin
      case (regAddr)
        amc_pkg::OFS_CFG: begin
          next_cfgEnable = regWdata[amc_pkg::CFG_EN_BIT];
          next_cfgRepeat = regWdata[amc_pkg::CFG_RPT_BIT];
          next_cfgPowerMode = regWdata[amc_pkg::CFG_PM_LSB +: 2];
          next_cfgTrigSel = regWdata[amc_pkg::CFG_TSEL_LSB +: 3];
          next_cfgTrigPol = regWdata[amc_pkg::CFG_TPOL_BIT];
        end
        amc_pkg::OFS_UPPER: next_upperLimit = regWdata[13:0];
        amc_pkg::OFS_LOWER: next_lowerLimit = regWdata[13:0];
        amc_pkg::OFS_INTEN: next_intEnable = regWdata[5:0];
        default: begin
          for (int i = 0; i < NS; i++) begin
            if (regAddr == amc_pkg::OFS_SLOT0 + 8'(4 * i)) begin
              next_slotCfg[i] = regWdata[7:0];
            end
          end
        end
      endcase
    end
    if (regRead) begin
      case (regAddr)
        amc_pkg::OFS_CFG: begin
          next_regRdata[amc_pkg::CFG_EN_BIT] = cfgEnable;
          next_regRdata[amc_pkg::CFG_RPT_BIT] = cfgRepeat;
          next_regRdata[amc_pkg::CFG_PM_LSB +: 2] = cfgPowerMode;
          next_regRdata[amc_pkg::CFG_TSEL_LSB +: 3] = cfgTrigSel;
          next_regRdata[amc_pkg::CFG_TPOL_BIT] = cfgTrigPol;
        end
        amc_pkg::OFS_STAT: begin
          next_regRdata[2:0] = stateCode;
          next_regRdata[3] = repeatArmed;
          next_regRdata[4] = pending;
          next_regRdata[5] = calibrated;
          next_regRdata[amc_pkg::STAT_CNT_LSB +: FCW] = fifoCount;
        end
        amc_pkg::OFS_UPPER: next_regRdata[13:0] = upperLimit;
        amc_pkg::OFS_LOWER: next_regRdata[13:0] = lowerLimit;
        amc_pkg::OFS_FIFO: begin
          // Reading has no side effect; a write pops
          next_regRdata[amc_pkg::FIFO_CNT_LSB +: FCW] = fifoCount;
          // Stale words left behind a flush never show as data
          if (fifoCount != '0) begin
            next_regRdata[13:0] = fifoHead[13:0];
            next_regRdata[amc_pkg::FIFO_SLOT_LSB +: 3] = fifoHead[16:14];
          end
        end
        amc_pkg::OFS_INTEN: next_regRdata[5:0] = intEnable;
        amc_pkg::OFS_INTSTAT: next_regRdata[5:0] = intStatus;
        default: begin
          for (int i = 0; i < NS; i++) begin
            if (regAddr == amc_pkg::OFS_SLOT0 + 8'(4 * i)) begin
              next_regRdata[7:0] = slotCfg[i];
            end
          end
        end
      endcase
    end
    next_intActive = |(next_intStatus & next_intEnable);
  end

  always_ff @(posedge clk or negedge rstIn_n) begin
    if (!rstIn_n) begin
      cfgEnable <= 1'b0;
      cfgRepeat <= 1'b0;
      cfgPowerMode <= 2'h0;
      cfgTrigSel <= 3'h0;
      cfgTrigPol <= 1'b0;
      slotCfg <= '{default: amc_pkg::SLOT_RESET};
      upperLimit <= amc_pkg::UPPER_RESET;
      lowerLimit <= amc_pkg::LOWER_RESET;
      intEnable <= 6'h00;
      intStatus <= 6'h00;
      regRdata <= 32'h0;
      intActive <= 1'b0;
    end else begin
      cfgEnable <= next_cfgEnable;
      cfgRepeat <= next_cfgRepeat;
      cfgPowerMode <= next_cfgPowerMode;
      cfgTrigSel <= next_cfgTrigSel;
      cfgTrigPol <= next_cfgTrigPol;
      slotCfg <= next_slotCfg;
      upperLimit <= next_upperLimit;
      lowerLimit <= next_lowerLimit;
      intEnable <= next_intEnable;
      intStatus <= next_intStatus;
      regRdata <= next_regRdata;
      intActive <= next_intActive;
    end
  end

  // ********************************
  // Scan and power group
  // ********************************
  amc_pkg::amc_state_t state, next_state;
  logic [amc_pkg::CNT_W-1:0] waitCnt, next_waitCnt;
  logic [2:0] next_sampleSlot;
  logic [3:0] next_sampleChannel;
  logic next_sampleReq, next_calibrateReq, next_fastClkReq;
  logic next_analogPowerOn, next_refBufferOn, next_convClockOn;
  logic next_repeatArmed, next_pending, next_calibrated;
  logic [3:0] extPrev, next_extPrev;
  logic timerPrev, next_timerPrev;
  logic [amc_pkg::ACC_W-1:0] acc [NS];
  logic [amc_pkg::ACC_W-1:0] next_acc [NS];
  logic [amc_pkg::AVG_CNT_W-1:0] avgCnt [NS];
  logic [amc_pkg::AVG_CNT_W-1:0] next_avgCnt [NS];
  logic [7:0] slotMask;
  logic [3:0] firstSlot, nextSlot;
  logic pinEdge, normalTrig, timerTrig, trigEvt, pendNow;
  logic fifoPush, fifoReady, fifoFlush;
  logic [amc_pkg::FIFO_W-1:0] fifoData;
  logic [amc_pkg::ACC_W-1:0] sum;
  logic [2:0] avgCode;
  logic [13:0] avgResult;

  assign stateCode = state;

  always_comb begin
    for (int i = 0; i < NS; i++) begin
      slotMask[i] = slotCfg[i][amc_pkg::SLOT_EN_BIT];
    end
    next_state = state;
    next_waitCnt = waitCnt;
    next_sampleSlot = sampleSlot;
    next_sampleChannel = sampleChannel;
    next_sampleReq = sampleReq;
    next_calibrateReq = 1'b0;
    next_fastClkReq = fastClkReq;
    next_analogPowerOn = analogPowerOn;
    next_refBufferOn = refBufferOn;
    next_convClockOn = convClockOn;
    next_calibrated = calibrated;
    next_acc = acc;
    next_avgCnt = avgCnt;
    next_extPrev = extTrigger;
    next_timerPrev = timerTrigger;
    intEvents = 6'h00;
    fifoPush = 1'b0;
    fifoData = '0;
    sum = '0;
    avgCode = 3'h0;
    avgResult = 14'h0;
    firstSlot = firstFrom(slotMask, 4'h0);
    nextSlot = firstFrom(slotMask, {1'b0, sampleSlot} + 4'h1);
    // Pin edge of the chosen polarity
    pinEdge = (extTrigger[cfgTrigSel[1:0]] ^ cfgTrigPol)
              && !(extPrev[cfgTrigSel[1:0]] ^ cfgTrigPol);
    normalTrig = (cfgTrigSel == amc_pkg::TRIG_SW) ? swTrigWrite :
                 (!cfgTrigSel[2] && pinEdge);
    // Timer pulses count only after the normal source has fired once
    timerTrig = cfgRepeat && repeatArmed && timerTrigger && !timerPrev;
    trigEvt = funcEnable && (slotMask != 8'h00) && (normalTrig || timerTrig);
    pendNow = pending || trigEvt;
    next_pending = pendNow;
    next_repeatArmed = cfgRepeat && (repeatArmed || (trigEvt && normalTrig));
    case (state)
      amc_pkg::ST_IDLE: begin
        if (pendNow && analogPowerOn) begin
          next_state = amc_pkg::ST_SAMPLE;
          next_sampleSlot = firstSlot[2:0];
          next_pending = 1'b0;
        end else if (pendNow) begin
          next_fastClkReq = 1'b1;
          next_state = amc_pkg::ST_CLK_WAIT;
        end
      end
      amc_pkg::ST_CLK_WAIT: begin
        if (fastClkAck) begin
          next_analogPowerOn = 1'b1;
          next_refBufferOn = 1'b1;
          next_convClockOn = 1'b1;
          // Calibration survives in every mode except mode two
          if (!calibrated || (cfgPowerMode == amc_pkg::POWER_MODE_TWO)) begin
            next_calibrateReq = 1'b1;
            next_waitCnt = amc_pkg::CNT_W'(COLD_CYCLES - 1);
          end else begin
            next_waitCnt = amc_pkg::CNT_W'(amc_pkg::WARM_CYCLES - 1);
          end
          next_state = amc_pkg::ST_WARM;
        end
      end
      amc_pkg::ST_WARM: begin
        if (waitCnt == '0) begin
          next_calibrated = 1'b1;
          next_sampleSlot = firstSlot[2:0];
          next_pending = 1'b0;
          next_state = amc_pkg::ST_SAMPLE;
        end else begin
          next_waitCnt = waitCnt - amc_pkg::CNT_W'(1);
        end
      end
      amc_pkg::ST_SAMPLE: begin
        next_sampleChannel = slotCfg[sampleSlot][amc_pkg::SLOT_CH_LSB +: 4];
        next_sampleReq = 1'b1;
        next_state = amc_pkg::ST_CONV_WAIT;
      end
      amc_pkg::ST_CONV_WAIT: begin
        if (sampleDone) begin
          next_sampleReq = 1'b0;
          avgCode = slotCfg[sampleSlot][amc_pkg::SLOT_AVG_LSB +: 3];
          sum = acc[sampleSlot] + amc_pkg::ACC_W'(sampleData);
          next_acc[sampleSlot] = sum;
          next_avgCnt[sampleSlot] = avgCnt[sampleSlot] + amc_pkg::AVG_CNT_W'(1);
          if (next_avgCnt[sampleSlot] == (amc_pkg::AVG_CNT_W'(1) << avgCode)) begin
            avgResult = 14'(sum >> avgCode);
            next_acc[sampleSlot] = '0;
            next_avgCnt[sampleSlot] = '0;
            // A full FIFO keeps its contents and the result is dropped
            fifoPush = fifoReady;
            fifoData = {sampleSlot, avgResult};
            intEvents[amc_pkg::INT_CONV] = fifoReady;
            intEvents[amc_pkg::INT_LVL1] = fifoReady
              && (fifoCount == FCW'(amc_pkg::FIFO_LVL_ONE - 1));
            intEvents[amc_pkg::INT_LVL2] = fifoReady
              && (fifoCount == FCW'(amc_pkg::FIFO_DEPTH - 1));
            if ((avgResult >= lowerLimit) && (avgResult <= upperLimit)) begin
              intEvents[amc_pkg::INT_IN] = fifoReady;
            end else begin
              intEvents[amc_pkg::INT_OUT] = fifoReady;
            end
          end
          if (nextSlot[3]) begin
            next_sampleSlot = nextSlot[2:0];
            next_state = amc_pkg::ST_SAMPLE;
          end else begin
            next_state = amc_pkg::ST_SCAN_END;
          end
        end
      end
      amc_pkg::ST_SCAN_END: begin
        intEvents[amc_pkg::INT_SCAN] = 1'b1;
        if (pendNow) begin
          // Burst straight into the next scan while powered
          next_sampleSlot = firstSlot[2:0];
          next_pending = 1'b0;
          next_state = amc_pkg::ST_SAMPLE;
        end else begin
          next_state = amc_pkg::ST_IDLE;
          if (cfgPowerMode != amc_pkg::POWER_MODE_ZERO) begin
            next_analogPowerOn = 1'b0;
            next_refBufferOn = 1'b0;
            next_convClockOn = 1'b0;
            next_fastClkReq = 1'b0;
            if (cfgPowerMode == amc_pkg::POWER_MODE_TWO) begin
              next_calibrated = 1'b0;
            end
          end
        end
      end
      default: next_state = amc_pkg::ST_IDLE;
    endcase
    fifoFlush = !funcEnable;
    // Disabling resets scan state, power, calibration, averages and FIFO; configuration, interrupt status, slot, channel and wait count keep their values
    if (!funcEnable) begin
      next_state = amc_pkg::ST_IDLE;
      next_sampleReq = 1'b0;
      next_calibrateReq = 1'b0;
      next_fastClkReq = 1'b0;
      next_analogPowerOn = 1'b0;
      next_refBufferOn = 1'b0;
      next_convClockOn = 1'b0;
      next_calibrated = 1'b0;
      next_pending = 1'b0;
      next_repeatArmed = 1'b0;
      next_acc = '{default: '0};
      next_avgCnt = '{default: '0};
      fifoPush = 1'b0;
      intEvents = 6'h00;
    end
  end

  always_ff @(posedge clk or negedge rstIn_n) begin
    if (!rstIn_n) begin
      state <= amc_pkg::ST_IDLE;
      waitCnt <= '0;
      sampleSlot <= 3'h0;
      sampleChannel <= 4'h0;
      sampleReq <= 1'b0;
      calibrateReq <= 1'b0;
      fastClkReq <= 1'b0;
      analogPowerOn <= 1'b0;
      refBufferOn <= 1'b0;
      convClockOn <= 1'b0;
      calibrated <= 1'b0;
      repeatArmed <= 1'b0;
      pending <= 1'b0;
      extPrev <= 4'h0;
      timerPrev <= 1'b0;
      acc <= '{default: '0};
      avgCnt <= '{default: '0};
    end else begin
      state <= next_state;
      waitCnt <= next_waitCnt;
      sampleSlot <= next_sampleSlot;
      sampleChannel <= next_sampleChannel;
      sampleReq <= next_sampleReq;
      calibrateReq <= next_calibrateReq;
      fastClkReq <= next_fastClkReq;
      analogPowerOn <= next_analogPowerOn;
      refBufferOn <= next_refBufferOn;
      convClockOn <= next_convClockOn;
      calibrated <= next_calibrated;
      repeatArmed <= next_repeatArmed;
      pending <= next_pending;
      extPrev <= next_extPrev;
      timerPrev <= next_timerPrev;
      acc <= next_acc;
      avgCnt <= next_avgCnt;
    end
  end

  // ********************************
  // Result FIFO
  // ********************************
  amc_result_fifo #(
    .WIDTH(amc_pkg::FIFO_W),
    .DEPTH(amc_pkg::FIFO_DEPTH),
    .CW(FCW)
  ) resultFifo (
    .clk(clk),
    .rstIn_n(rstIn_n),
    .flush(fifoFlush),
    .push(fifoPush),
    .pushData(fifoData),
    .pushReady(fifoReady),
    .pop(fifoPop),
    .headData(fifoHead),
    .count(fifoCount)
  );

endmodule : amc_scan_controller

// *** amc_pkg.sv ***
package amc_pkg;

  // ********************************
  // Timing
  // ********************************
  localparam int CLK_MHZ = 40;
  localparam int WARM_US = 50;
  localparam int COLD_US = 650;
  localparam int WARM_CYCLES = WARM_US * CLK_MHZ;
  localparam int COLD_CYCLES = COLD_US * CLK_MHZ;
  localparam int CNT_W = 16;

  // ********************************
  // Sizes
  // ********************************
  localparam int NUM_SLOTS = 8;
  localparam int SAMPLE_W = 14;
  localparam int AVG_CNT_W = 8;
  localparam int ACC_W = 21;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_LVL_ONE = 12;
  localparam int FIFO_W = 17;
  localparam int NUM_INTS = 6;

  // ********************************
  // Register offsets
  // ********************************
  localparam logic [7:0] OFS_CFG = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_SWT = 8'h08;
  localparam logic [7:0] OFS_SLOT0 = 8'h0c;
  localparam logic [7:0] OFS_UPPER = 8'h2c;
  localparam logic [7:0] OFS_LOWER = 8'h30;
  localparam logic [7:0] OFS_FIFO = 8'h38;
  localparam logic [7:0] OFS_INTEN = 8'h40;
  localparam logic [7:0] OFS_INTSTAT = 8'h44;
  localparam logic [7:0] OFS_INTCLR = 8'h48;

  // ********************************
  // Field positions
  // ********************************
  localparam int CFG_EN_BIT = 0;
  localparam int CFG_RPT_BIT = 2;
  localparam int CFG_PM_LSB = 3;
  localparam int CFG_TSEL_LSB = 16;
  localparam int CFG_TPOL_BIT = 19;
  localparam int SLOT_EN_BIT = 0;
  localparam int SLOT_AVG_LSB = 1;
  localparam int SLOT_CH_LSB = 4;
  localparam int FIFO_CNT_LSB = 16;
  localparam int FIFO_SLOT_LSB = 24;
  localparam int STAT_CNT_LSB = 8;
  localparam int INT_CONV = 0;
  localparam int INT_SCAN = 1;
  localparam int INT_LVL1 = 2;
  localparam int INT_LVL2 = 3;
  localparam int INT_OUT = 4;
  localparam int INT_IN = 5;

  // ********************************
  // Reset values and codes
  // ********************************
  localparam logic [7:0] SLOT_RESET = 8'h00;
  localparam logic [13:0] UPPER_RESET = 14'h3fff;
  localparam logic [13:0] LOWER_RESET = 14'h0000;
  localparam logic [2:0] TRIG_SW = 3'h7;

  typedef enum logic [1:0] {
    POWER_MODE_ZERO = 2'h0,
    POWER_MODE_ONE = 2'h1,
    POWER_MODE_TWO = 2'h2
  } amc_pmode_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CLK_WAIT = 3'b001,
    ST_WARM = 3'b011,
    ST_SAMPLE = 3'b010,
    ST_CONV_WAIT = 3'b110,
    ST_SCAN_END = 3'b111
  } amc_state_t;

endpackage : amc_pkg

// *** amc_result_fifo.sv ***
module amc_result_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 16,
  parameter int CW = $clog2(DEPTH + 1)
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstIn_n,
  // Control
  input wire logic flush,
  input wire logic push,
  input wire logic [WIDTH-1:0] pushData,
  output logic pushReady,
  input wire logic pop,
  // Head and level
  output logic [WIDTH-1:0] headData,
  output logic [CW-1:0] count
);

  // Pointers wrap naturally, so DEPTH must be a power of two
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [WIDTH-1:0] next_mem [DEPTH];
  logic [PW-1:0] wrPtr, next_wrPtr, rdPtr, next_rdPtr;
  logic [CW-1:0] next_count;
  logic doPush, doPop;

  assign pushReady = (count != CW'(DEPTH));
  assign headData = mem[rdPtr];

  always_comb begin
    doPush = push && pushReady;
    doPop = pop && (count != '0);
    next_mem = mem;
    next_wrPtr = wrPtr;
    next_rdPtr = rdPtr;
    next_count = count;
    if (flush) begin
      next_wrPtr = '0;
      next_rdPtr = '0;
      next_count = '0;
    end else begin
      if (doPush) begin
        next_mem[wrPtr] = pushData;
        next_wrPtr = wrPtr + PW'(1);
      end
      if (doPop) begin
        next_rdPtr = rdPtr + PW'(1);
      end
      next_count = count + CW'(doPush) - CW'(doPop);
    end
  end

  always_ff @(posedge clk or negedge rstIn_n) begin
    if (!rstIn_n) begin
      mem <= '{default: '0};
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      mem <= next_mem;
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
      count <= next_count;
    end
  end

endmodule : amc_result_fifo

// *** amc_scan_props.sv ***
module amc_scan_props (
  // Watched ports
  input wire logic clk,
  input wire logic rst_n,
  input wire logic regRead,
  input wire logic [31:0] regRdata,
  input wire logic subsystemPowerEnable,
  input wire logic fastClkReq,
  input wire logic fastClkAck,
  input wire logic analogPowerOn,
  input wire logic refBufferOn,
  input wire logic convClockOn,
  input wire logic calibrateReq,
  input wire logic sampleReq,
  input wire logic [2:0] sampleSlot,
  input wire logic sampleDone
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_rdata_quiet: assert property (!$past(regRead) |-> regRdata == 32'h0)
    else $error("read data outside its slot");
  a_slot_steady: assert property (sampleReq && $past(sampleReq) |-> $stable(sampleSlot))
    else $error("slot moved during a sample");
  a_req_release: assert property (sampleDone |=> !sampleReq)
    else $error("sample request held past done");
  a_power_gate: assert property (!subsystemPowerEnable [*3] |-> !sampleReq && !analogPowerOn)
    else $error("activity without subsystem power");
  a_sample_powered: assert property (sampleReq |-> analogPowerOn && refBufferOn && convClockOn)
    else $error("sampling while converter unpowered");
  a_clock_granted: assert property (sampleReq |-> fastClkReq && fastClkAck)
    else $error("sampling without granted fast clock");
  a_cold_settle: assert property (calibrateReq |=> !sampleReq [*8])
    else $error("sampling too soon after cold start");
  a_cal_pulse: assert property (calibrateReq |=> !calibrateReq)
    else $error("calibration request too long");
  a_sleep_clean: assert property ($fell(analogPowerOn) |-> !sampleReq && !$past(sampleReq))
    else $error("power dropped during a sample");
  c_slot_two: cover property ($rose(sampleReq) && sampleSlot == 3'h2);
  c_cold: cover property (calibrateReq);
  c_sleep: cover property ($fell(analogPowerOn));
endmodule : amc_scan_props

bind amc_scan_controller amc_scan_props amc_scan_props_inst (.*);

// *** amc_analog_model.sv ***
module amc_analog_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Converter side
  input wire logic sampleReq,
  input wire logic slow,
  output logic sampleDone,
  output logic [13:0] sampleData,
  output logic [15:0] samples,
  // Clock generator side
  input wire logic fastClkReq,
  output logic fastClkAck
);
  logic [1:0] ackPipe;
  logic [2:0] lag;
  logic [13:0] held;
  logic go;
  assign go = sampleReq && !sampleDone && lag >= (slow ? 3'h4 : 3'h0);
  assign fastClkAck = ackPipe[1];
  // Idle bus shows the inverse so a stale value never passes
  assign sampleData = sampleDone ? held : ~held;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {ackPipe, lag, held, sampleDone, samples} <= '0;
    end else begin
      ackPipe <= {ackPipe[0], fastClkReq};
      lag <= (sampleReq && !sampleDone) ? lag + 3'h1 : 3'h0;
      sampleDone <= go;
      if (go) begin
        held <= samples[0] ? 14'h108 : 14'h100;
        samples <= samples + 16'h1;
      end
    end
  end
endmodule : amc_analog_model

// *** test_amc_scan_controller.sv ***
module test_amc_scan_controller;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_n = 1'b0, regWrite = 1'b0, regRead = 1'b0, timerTrigger = 1'b0;
  logic subsystemPowerEnable = 1'b0, slow = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0, regRdata, d;
  logic [3:0] extTrigger = 4'h0, sampleChannel;
  logic fastClkReq, fastClkAck, analogPowerOn, refBufferOn, convClockOn, calibrateReq;
  logic sampleReq, sampleDone, intActive;
  logic [2:0] sampleSlot;
  logic [13:0] sampleData;
  logic [15:0] samples;
  int error_cnt = 0, samples_checked = 0, cycles = 0;
  // Cold start shortened so the run stays short
  amc_scan_controller #(.COLD_CYCLES(20)) amc_scan_controller_inst (.*);
  amc_analog_model amc_analog_model_inst (.*);
  initial begin
    forever #12.5 clk = ~clk;
  end
  // ********************************
  // Bus and compare tasks
  // ********************************
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    {regAddr, regWdata, regWrite} <= {a, v, 1'b1};
    @(posedge clk);
    regWrite <= 1'b0;
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    {regAddr, regRead} <= {a, 1'b1};
    @(posedge clk);
    regRead <= 1'b0;
    #1 d = regRdata;
    chk(d, e);
  endtask : rc
  task automatic cfg(input logic en, rpt, input logic [1:0] pm, input logic [2:0] ts,
                     input logic pol);
    wr(amc_pkg::OFS_CFG, {12'h0, pol, ts, 11'h0, pm, rpt, 1'b0, en});
  endtask : cfg
  task automatic waitn(input int n);
    for (int i = 0; i < 3000 && samples !== 16'(n); i++) @(posedge clk);
    chk(32'(samples), 32'(n));
    repeat (6) @(posedge clk);
  endtask : waitn
  task automatic fifo(input logic [2:0] s, input logic [4:0] n, input logic [13:0] v);
    rc(amc_pkg::OFS_FIFO, {5'h0, s, 3'h0, n, 2'h0, v});
    wr(amc_pkg::OFS_FIFO, 32'h0);
  endtask : fifo
  task automatic pulse(input int who);
    @(posedge clk);
    if (who < 0) timerTrigger <= 1'b1; else extTrigger <= 4'h0;
    repeat (3) @(posedge clk);
    {timerTrigger, extTrigger} <= 5'h04;
  endtask : pulse
  // ********************************
  // Scenarios
  // ********************************
  task automatic t_single;
    cfg(1'b1, 1'b0, 2'h0, amc_pkg::TRIG_SW, 1'b0);
    wr(amc_pkg::OFS_SWT, 32'h0);
    repeat (40) @(posedge clk);
    chk(32'(samples), 32'h0);
    wr(amc_pkg::OFS_SLOT0, 32'h13);
    wr(amc_pkg::OFS_SLOT0 + 8'h08, 32'h31);
    wr(amc_pkg::OFS_INTEN, 32'h3);
    wr(amc_pkg::OFS_SWT, 32'h0);
    waitn(2);
    rc(amc_pkg::OFS_INTSTAT, 32'h23);
    chk(32'(intActive), 32'h1);
    fifo(3'h2, 5'h1, 14'h108);
    wr(amc_pkg::OFS_SWT, 32'h0);
    waitn(4);
    fifo(3'h0, 5'h2, 14'h100);
    fifo(3'h2, 5'h1, 14'h108);
    wr(amc_pkg::OFS_INTCLR, 32'h3f);
    rc(amc_pkg::OFS_INTSTAT, 32'h0);
    rc(8'hfc, 32'h0);
    $display("t_single done");
  endtask : t_single
  task automatic t_avg;
    cfg(1'b0, 1'b0, 2'h0, amc_pkg::TRIG_SW, 1'b0);
    wr(amc_pkg::OFS_SLOT0 + 8'h08, 32'h0);
    wr(amc_pkg::OFS_SLOT0, 32'h13);
    cfg(1'b1, 1'b0, 2'h0, amc_pkg::TRIG_SW, 1'b0);
    wr(amc_pkg::OFS_SWT, 32'h0);
    waitn(5);
    wr(amc_pkg::OFS_SWT, 32'h0);
    waitn(6);
    fifo(3'h0, 5'h1, 14'h104);
    $display("t_avg done");
  endtask : t_avg
  task automatic t_repeat;
    cfg(1'b1, 1'b1, 2'h0, amc_pkg::TRIG_SW, 1'b0);
    pulse(-1);
    repeat (40) @(posedge clk);
    chk(32'(samples), 32'h6);
    wr(amc_pkg::OFS_SWT, 32'h0);
    waitn(7);
    for (int k = 8; k < 10; k++) begin
      pulse(-1);
      waitn(k);
    end
    $display("t_repeat done");
  endtask : t_repeat
  task automatic t_ext;
    cfg(1'b0, 1'b0, 2'h1, 3'h2, 1'b1);
    rc(amc_pkg::OFS_FIFO, 32'h0);
    cfg(1'b1, 1'b0, 2'h1, 3'h2, 1'b1);
    slow <= 1'b1;
    extTrigger <= 4'h4;
    repeat (40) @(posedge clk);
    chk(32'(samples), 32'h9);
    pulse(1);
    waitn(10);
    chk(32'(analogPowerOn), 32'h0);
    pulse(1);
    waitn(11);
    $display("t_ext done");
  endtask : t_ext
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    {rst_n, subsystemPowerEnable} <= 2'h3;
    repeat (3) @(posedge clk);
    t_single();
    t_avg();
    t_repeat();
    t_ext();
    report_and_stop();
  end
endmodule : test_amc_scan_controller
